// File: hw/acalc_params.svh
// constants of the converter control block: offsets, fields, resets, timing
`ifndef ACALC_PARAMS_SVH
`define ACALC_PARAMS_SVH
// register byte offsets on the APB
`define ACALC_OFF_CFG 8'h00
`define ACALC_OFF_TCC 8'h04
`define ACALC_OFF_CIC 8'h08
`define ACALC_OFF_RESH 8'h0C
`define ACALC_OFF_RESL 8'h10
`define ACALC_OFF_CMPH 8'h14
`define ACALC_OFF_CMPL 8'h18
`define ACALC_OFF_PIN1 8'h1C
`define ACALC_OFF_PIN2 8'h20
// field positions
`define ACALC_CFG_LPC 7
`define ACALC_CFG_DIV_HI 6
`define ACALC_CFG_DIV_LO 5
`define ACALC_CFG_LSMP 4
`define ACALC_CFG_MODE_HI 3
`define ACALC_CFG_MODE_LO 2
`define ACALC_CFG_ICLK_HI 1
`define ACALC_CFG_ICLK_LO 0
`define ACALC_TCC_ACT 7
`define ACALC_TCC_TRG 6
`define ACALC_TCC_CFE 5
`define ACALC_TCC_CGT 4
`define ACALC_CIC_COMPLETION_FLAG 7
`define ACALC_CIC_COMPLETION_IRQ_ENABLE 6
`define ACALC_CIC_CONTINUOUS_SELECT 5
// encodings
`define ACALC_MODE_8 2'h0
`define ACALC_MODE_12 2'h1
`define ACALC_MODE_10 2'h2
`define ACALC_ICLK_BUS 2'h0
`define ACALC_ICLK_BUS2 2'h1
`define ACALC_ICLK_ASYNC 2'h3
// reset values
`define ACALC_RST_BYTE 8'h00
`define ACALC_RST_WORD 12'h000
// sampling length in half conversion-clock cycles (3.5 and 23.5 cycles)
`define ACALC_SAMP_SHORT_X2 6'h07
`define ACALC_SAMP_LONG_X2 6'h2F
`endif

// File: hw/acalc_pkg.sv
// types of the converter control block
package acalc_pkg;
    // conversion sequencer, gray coded along idle-sample-convert-done
    typedef enum logic [1:0] {
        ACALC_IDLE = 2'h0,
        ACALC_SAMPLE = 2'h1,
        ACALC_CONVERT = 2'h3,
        ACALC_DONE = 2'h2
    } acalc_state_e;

    // complete state of the block
    typedef struct packed {
        acalc_state_e st;
        logic [7:0] cfg;
        logic trg;
        logic cfe;
        logic cgt;
        logic [1:0] rsv;
        logic completion_flag;
        logic completion_irq_enable;
        logic continuous_select;
        logic [4:0] ch;
        logic [11:0] res;
        logic [11:0] cmp;
        logic [15:0] pinc;
        logic lock;
        logic [9:0] cnt;
        logic dstop_s1;
        logic dstop_s2;
        logic lstop_s1;
        logic lstop_s2;
        logic htrg_s1;
        logic htrg_s2;
        logic htrg_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic active;
    } acalc_state_s;
endpackage : acalc_pkg

// File: hw/acalc_top.sv
// converter control: configuration, triggering, result guard and low power
`timescale 1ns/1ps
`default_nettype none
`include "acalc_params.svh"

module acalc_top
    import acalc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic deepest_stop_a,
    input wire logic deepest_stop_b,
    input wire logic light_stop,
    input wire logic hw_trigger,
    input wire logic [11:0] sar_code,
    input wire logic above_high_ref,
    input wire logic below_low_ref,
    output logic completion_irq,
    output logic conversion_active,
    output logic [4:0] channel_sel,
    output logic [15:0] pin_analog_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // state and helpers

    acalc_state_s r; // registered state
    acalc_state_s n; // next state
    logic [4:0] pdiv; // bus cycles per conversion clock
    logic [10:0] samp; // sample length in bus cycles
    logic [9:0] conv; // approximation length in bus cycles
    logic [3:0] nbits; // active resolution
    logic [11:0] full; // full-scale code
    logic [11:0] code; // clamped, justified code
    logic [11:0] diff; // result minus compare value
    logic hit; // compare condition met
    logic store; // completing conversion may transfer
    logic acc; // completing apb access
    logic wr_cic; // write to channel register this edge
    logic lstop_abort; // light stop without async clock
    logic quiet; // no abort source this cycle
    logic [31:0] rdat; // read mux
    logic known; // mapped address

    localparam acalc_state_s ACALC_RST = '0;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    // one pass computes every field of the next state
    always_comb begin
        n = r;
        // pin inputs: two flops, the first read only by the second
        n.dstop_s1 = deepest_stop_a | deepest_stop_b;
        n.dstop_s2 = r.dstop_s1;
        n.lstop_s1 = light_stop;
        n.lstop_s2 = r.lstop_s1;
        n.htrg_s1 = hw_trigger;
        n.htrg_s2 = r.htrg_s1;
        n.htrg_prev = r.htrg_s2;

        // conversion clock: source divide times 2^div, 00 passes through
        pdiv = 5'h01 << r.cfg[`ACALC_CFG_DIV_HI:`ACALC_CFG_DIV_LO];
        if (r.cfg[`ACALC_CFG_ICLK_HI:`ACALC_CFG_ICLK_LO] == `ACALC_ICLK_BUS2) begin
            pdiv = {pdiv[3:0], 1'b0};
        end
        // sample length rounded up to whole bus cycles
        if (r.cfg[`ACALC_CFG_LSMP]) begin
            samp = 11'((`ACALC_SAMP_LONG_X2 * pdiv + 1) >> 1);
        end else begin
            samp = 11'((`ACALC_SAMP_SHORT_X2 * pdiv + 1) >> 1);
        end
        // resolution select
        case (r.cfg[`ACALC_CFG_MODE_HI:`ACALC_CFG_MODE_LO])
            `ACALC_MODE_12: nbits = 4'hC;
            `ACALC_MODE_10: nbits = 4'hA;
            default: nbits = 4'h8;
        endcase
        conv = 10'(nbits * pdiv);
        full = 12'hFFF >> (4'hC - nbits);

        // clamp at the references, justify to the width
        if (above_high_ref) begin
            code = full;
        end else if (below_low_ref) begin
            code = 12'h000;
        end else begin
            code = sar_code >> (4'hC - nbits);
        end
        diff = code - r.cmp;
        hit = r.cgt ? (code >= r.cmp) : (code < r.cmp);

        lstop_abort = r.lstop_s2 &&
            (r.cfg[`ACALC_CFG_ICLK_HI:`ACALC_CFG_ICLK_LO] != `ACALC_ICLK_ASYNC);
        // a result finishing under light stop is dropped with the abort
        store = (r.st == ACALC_DONE) && !r.lock && !lstop_abort && (!r.cfe || hit);
        // an access completes on the edge where pready already stands high
        acc = psel && penable && r.pready;
        wr_cic = acc && pwrite && (paddr[7:0] == `ACALC_OFF_CIC);
        quiet = !r.dstop_s2 && !lstop_abort && !wr_cic;

        // conversion sequencer
        case (r.st)
            ACALC_IDLE: begin
                // hardware trigger edge starts a conversion
                if (r.trg && r.htrg_s2 && !r.htrg_prev) begin
                    n.st = ACALC_SAMPLE;
                    n.cnt = 10'h000;
                end
            end
            ACALC_SAMPLE: begin
                // input tracked for the sample window
                n.cnt = r.cnt + 10'h001;
                // at or past the end, so a mid-window config write cannot overrun
                if ({1'b0, r.cnt} >= samp - 11'h001) begin
                    n.st = ACALC_CONVERT;
                    n.cnt = 10'h000;
                end
            end
            ACALC_CONVERT: begin
                // one conversion clock per bit
                n.cnt = r.cnt + 10'h001;
                // same guard against a shorter width chosen mid-conversion
                if (r.cnt >= conv - 10'h001) begin
                    n.st = ACALC_DONE;
                end
            end
            default: begin
                // repeat or stop after one
                n.cnt = 10'h000;
                n.st = r.continuous_select ? ACALC_SAMPLE : ACALC_IDLE;
            end
        endcase

        // light stop aborts unless the clock source is async, results untouched
        if (lstop_abort) begin
            n.st = ACALC_IDLE;
        end

        // apb: answer one cycle into the access phase
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        known = 1'b1;
        rdat = 32'h0000_0000;
        if (paddr[7:0] == `ACALC_OFF_CFG) begin
            rdat[7:0] = r.cfg;
        end else if (paddr[7:0] == `ACALC_OFF_TCC) begin
            // middle bits read zero, low reserved bits read back
            rdat[7:0] = {r.st != ACALC_IDLE, r.trg, r.cfe, r.cgt, 2'h0, r.rsv};
        end else if (paddr[7:0] == `ACALC_OFF_CIC) begin
            rdat[7:0] = {r.completion_flag, r.completion_irq_enable, r.continuous_select, r.ch};
        end else if (paddr[7:0] == `ACALC_OFF_RESH) begin
            rdat[3:0] = r.res[11:8];
        end else if (paddr[7:0] == `ACALC_OFF_RESL) begin
            rdat[7:0] = r.res[7:0];
        end else if (paddr[7:0] == `ACALC_OFF_CMPH) begin
            rdat[3:0] = r.cmp[11:8];
        end else if (paddr[7:0] == `ACALC_OFF_CMPL) begin
            rdat[7:0] = r.cmp[7:0];
        end else if (paddr[7:0] == `ACALC_OFF_PIN1) begin
            rdat[7:0] = r.pinc[7:0];
        end else if (paddr[7:0] == `ACALC_OFF_PIN2) begin
            rdat[7:0] = r.pinc[15:8];
        end else begin
            known = 1'b0;
        end
        if (psel && penable && !r.pready) begin
            n.pready = 1'b1;
            n.pslverr = !known || (paddr[31:8] != 24'h000000) || (paddr[1:0] != 2'h0);
            n.prdata = pwrite ? 32'h0000_0000 : rdat;
        end

        // effects land on the edge that completes the access
        // a refused write leaves every register as it was
        if (acc && pwrite && !r.pslverr) begin
            if (paddr[7:0] == `ACALC_OFF_CFG) begin
                n.cfg = pwdata[7:0];
            end else if (paddr[7:0] == `ACALC_OFF_TCC) begin
                n.trg = pwdata[`ACALC_TCC_TRG];
                n.cfe = pwdata[`ACALC_TCC_CFE];
                n.cgt = pwdata[`ACALC_TCC_CGT];
                n.rsv = pwdata[1:0];
            end else if (paddr[7:0] == `ACALC_OFF_CIC) begin
                // write clears the flag and, in software mode, starts
                n.completion_irq_enable = pwdata[`ACALC_CIC_COMPLETION_IRQ_ENABLE];
                n.continuous_select = pwdata[`ACALC_CIC_CONTINUOUS_SELECT];
                n.ch = pwdata[4:0];
                n.completion_flag = 1'b0;
                n.cnt = 10'h000;
                n.st = r.trg ? ACALC_IDLE : ACALC_SAMPLE;
            end else if (paddr[7:0] == `ACALC_OFF_CMPH) begin
                n.cmp[11:8] = pwdata[3:0];
            end else if (paddr[7:0] == `ACALC_OFF_CMPL) begin
                n.cmp[7:0] = pwdata[7:0];
            end else if (paddr[7:0] == `ACALC_OFF_PIN1) begin
                n.pinc[7:0] = pwdata[7:0];
            end else if (paddr[7:0] == `ACALC_OFF_PIN2) begin
                n.pinc[15:8] = pwdata[7:0];
            end
        end
        // high read locks the pair, low read releases it and clears the flag
        if (acc && !pwrite && paddr[7:0] == `ACALC_OFF_RESH) begin
            n.lock = 1'b1;
        end
        if (acc && !pwrite && paddr[7:0] == `ACALC_OFF_RESL) begin
            n.lock = 1'b0;
            n.completion_flag = 1'b0;
        end

        // completion sets after any clear, so a same-cycle event wins
        if (store) begin
            n.completion_flag = 1'b1;
            n.res = r.cfe ? diff : code;
        end

        n.active = (n.st != ACALC_IDLE);
        n.irq = n.completion_flag && n.completion_irq_enable;

        // deepest stop: everything back to reset, pin syncs kept
        if (r.dstop_s2) begin
            n = ACALC_RST;
            // first flop follows the pins alone, so the exit is seen
            n.dstop_s1 = deepest_stop_a | deepest_stop_b;
            n.dstop_s2 = r.dstop_s1;
            n.lstop_s1 = light_stop;
            n.lstop_s2 = r.lstop_s1;
            n.htrg_s1 = hw_trigger;
            n.htrg_s2 = r.htrg_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // single register stage for all state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= ACALC_RST;
        end else begin
            r <= n;
        end
    end

    // outputs straight from flops
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign prdata = r.prdata;
    assign completion_irq = r.irq;
    assign conversion_active = r.active;
    assign channel_sel = r.ch;
    assign pin_analog_mode = r.pinc;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking acalc_cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_sample_end;
        r.st == ACALC_SAMPLE && {1'b0, r.cnt} == samp - 11'h001 && quiet;
    endsequence
    sequence s_done_single;
        r.st == ACALC_DONE && !r.continuous_select && quiet;
    endsequence
    sequence s_tcc_read;
        psel && penable && !r.pready && !pwrite && paddr == 32'h0000_0004;
    endsequence

    // deepest stop clears the whole block
    deep_stop_reset_a: assert property (r.dstop_s2 |=> r.st == ACALC_IDLE && r.cfg == 8'h00 && !r.completion_flag)
        else $error("deepest stop left state");
    deep_stop_regs_a: assert property (r.dstop_s2 ##1 r.dstop_s2 |=> r.res == 12'h000 && r.pinc == 16'h0000)
        else $error("registers not reset");
    // sequencer timing
    sample_length_a: assert property (s_sample_end |=> r.st == ACALC_CONVERT)
        else $error("sample window wrong");
    sample_hold_a: assert property (r.st == ACALC_SAMPLE && {1'b0, r.cnt} < samp - 11'h001 && quiet
        |=> r.st == ACALC_SAMPLE)
        else $error("sample ended early");
    // register read views, interrupt and single mode
    active_flag_a: assert property (s_tcc_read |=> r.prdata[7] == $past(r.st != ACALC_IDLE))
        else $error("activity flag wrong");
    reserved_zero_a: assert property (s_tcc_read |=> r.prdata[3:2] == 2'h0)
        else $error("reserved bits not zero");
    irq_follow_a: assert property (r.completion_flag && r.completion_irq_enable |-> completion_irq)
        else $error("irq missing");
    one_shot_a: assert property (s_done_single |=> r.st == ACALC_IDLE)
        else $error("single mode repeated");
    // result path: clamps, guard, compare and light stop
    clamp_high_a: assert property (r.st == ACALC_DONE && !r.cfe && !r.lock && above_high_ref && !r.dstop_s2
        && !lstop_abort |=> r.res == $past(full))
        else $error("no full scale");
    clamp_low_a: assert property (r.st == ACALC_DONE && !r.cfe && !r.lock && !above_high_ref && below_low_ref
        && !r.dstop_s2 && !lstop_abort |=> r.res == 12'h000)
        else $error("no zero code");
    result_lock_a: assert property (r.st == ACALC_DONE && r.lock && !r.dstop_s2 |=> $stable(r.res))
        else $error("locked result overwritten");
    compare_miss_a: assert property (r.st == ACALC_DONE && r.cfe && !hit && !r.dstop_s2
        |=> $stable(r.res))
        else $error("compare miss stored");
    light_stop_a: assert property (lstop_abort && !r.dstop_s2 && !wr_cic
        |=> r.st == ACALC_IDLE && $stable(r.res))
        else $error("light stop did not abort");
    // pin control follows its writes
    pin_mode_a: assert property (acc && pwrite && !r.pslverr && paddr[7:0] == `ACALC_OFF_PIN1
        && !r.dstop_s2 |=> pin_analog_mode[7:0] == $past(pwdata[7:0]))
        else $error("pin mode mismatch");

endmodule : acalc_top
`default_nettype wire

// File: dv/acalc_analog_model.sv
// analog array stand-in: code, reference clamps and hardware trigger
`timescale 1ns/1ps
`default_nettype none

module acalc_analog_model (
    input wire logic clk,
    input wire logic [1:0] level, // 0 linear, 1 at high ref, 2 at low ref
    input wire logic [11:0] code, // raw code, msb justified
    input wire logic trig_req, // hardware trigger level request
    output logic [11:0] sar_code,
    output logic above_high_ref,
    output logic below_low_ref,
    output logic hw_trigger
);
    ////////////////////////////////////////////////////////////////////////
    // array settles one bus cycle after the bench moves the input
    always_ff @(posedge clk) begin
        sar_code <= code;
        above_high_ref <= (level == 2'h1);
        below_low_ref <= (level == 2'h2);
        hw_trigger <= trig_req;
    end
endmodule : acalc_analog_model

`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, dsa = 1'b0, dsb = 1'b0, ls = 1'b0, trig = 1'b0;
    logic [1:0] level = 2'h0;
    logic [11:0] code = 12'h000, sar, r;
    logic ahr, blr, hwt, irq, act;
    logic [4:0] chs;
    logic [15:0] pam;
    int errors = 0, comparisons = 0, d0, d, rnd;
    logic [7:0] cfgs [4] = '{8'h10, 8'h20, 8'h30, 8'h01}; // divider and sample settings

    always #5 clk = ~clk;

    acalc_top uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .deepest_stop_a(dsa), .deepest_stop_b(dsb), .light_stop(ls), .hw_trigger(hwt),
        .sar_code(sar), .above_high_ref(ahr), .below_low_ref(blr), .completion_irq(irq),
        .conversion_active(act), .channel_sel(chs), .pin_analog_mode(pam));
    acalc_analog_model far (.clk(clk), .level(level), .code(code), .trig_req(trig),
        .sar_code(sar), .above_high_ref(ahr), .below_low_ref(blr), .hw_trigger(hwt));

    ////////////////////////////////////////////////////////////////////////
    // verdict, single exit point
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; request held until pready seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= dat;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'h0, v});
    endtask : wr

    // result pair, high byte first so the pair is guarded
    task automatic rd_res;
        apb(1'b0, 8'h0C, 32'h0);
        r[11:8] = rd[3:0];
        apb(1'b0, 8'h10, 32'h0);
        r[7:0] = rd[7:0];
    endtask : rd_res

    // start by channel write, measure cycles with the sequencer busy
    task automatic run_conv(input logic [7:0] cic);
        int n;
        n = 0;
        wr(8'h08, cic);
        d = 0;
        while (act !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        while (act === 1'b1 && d < 400) begin
            @(negedge clk);
            d++;
        end
        if (n >= 20 || d >= 400) begin
            errors++;
            tally_and_finish();
        end
        repeat (3) @(posedge clk);
    endtask : run_conv

    // stored value: clamp, then right-justify to the mode width
    function automatic logic [31:0] exp_res(input logic [1:0] m, input logic [1:0] l, input logic [11:0] c);
        logic [11:0] v;
        v = (m == 2'h1) ? c : (m == 2'h2) ? {2'h0, c[11:2]} : {4'h0, c[11:4]};
        if (l == 2'h1) v = (m == 2'h1) ? 12'hFFF : (m == 2'h2) ? 12'h3FF : 12'h0FF;
        if (l == 2'h2) v = 12'h000;
        return {20'h0, v};
    endfunction : exp_res

    // busy span: rounded-up sample, one clock per bit, all times the divide
    function automatic int span(input logic [7:0] c);
        int p;
        p = (1 << c[6:5]) * ((c[1:0] == 2'h1) ? 2 : 1);
        return ((c[4] ? 47 : 7) * p + 1) / 2 + ((c[3:2] == 2'h1) ? 12 : (c[3:2] == 2'h2) ? 10 : 8) * p;
    endfunction : span

    ////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        rnd = $urandom(32'h6c6b);
        for (int a = 0; a <= 32; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, 8'h24, 32'h0);
        check({31'h0, err}, 32'h1);
        wr(8'h00, 8'h98);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h98);
        wr(8'h04, 8'h7C);
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h70);
        wr(8'h04, 8'h00);
        wr(8'h1C, 8'h02);
        wr(8'h20, 8'h81);
        @(posedge clk);
        check({16'h0, pam}, 32'h8102);
        // modes 00, 01 and 10 against linear, top and bottom of the range
        for (int m = 0; m < 3; m++) begin
            for (int l = 0; l < 3; l++) begin
                level <= 2'(l);
                code <= 12'($urandom);
                wr(8'h00, {4'h0, 2'(m), 2'h0});
                run_conv(8'h41);
                check({27'h0, chs}, 32'h1);
                check({31'h0, irq}, 32'h1);
                apb(1'b0, 8'h08, 32'h0);
                check(rd, 32'hC1);
                rd_res();
                check({20'h0, r}, exp_res(2'(m), 2'(l), code));
                apb(1'b0, 8'h08, 32'h0);
                check(rd, 32'h41);
            end
        end
        level <= 2'h0;
        // sample length and divider against the shortest setting
        wr(8'h00, 8'h00);
        run_conv(8'h01);
        d0 = d;
        foreach (cfgs[i]) begin
            wr(8'h00, cfgs[i]);
            run_conv(8'h01);
            check(d - d0, span(cfgs[i]) - span(8'h00));
        end
        // compare above and below the threshold 0x800
        wr(8'h00, 8'h04);
        wr(8'h14, 8'h08);
        wr(8'h18, 8'h00);
        wr(8'h04, 8'h30);
        code <= 12'h9A5;
        run_conv(8'h01);
        rd_res();
        check({20'h0, r}, 32'h1A5);
        code <= 12'h123;
        run_conv(8'h01);
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h01);
        wr(8'h04, 8'h20);
        run_conv(8'h01);
        rd_res();
        check({20'h0, r}, 32'h923);
        // hardware trigger
        wr(8'h04, 8'h40);
        code <= 12'h5A5;
        trig <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, act}, 32'h1);
        trig <= 1'b0;
        repeat (40) @(posedge clk);
        wr(8'h04, 8'h00);
        // high byte read guards the pair against the next result
        apb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h5);
        code <= 12'h111;
        run_conv(8'h01);
        apb(1'b0, 8'h10, 32'h0);
        check(rd, 32'hA5);
        // light stop aborts, results untouched
        wr(8'h00, 8'h14);
        wr(8'h08, 8'h01);
        repeat (3) @(posedge clk);
        ls <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, act}, 32'h0);
        ls <= 1'b0;
        rd_res();
        check({20'h0, r}, 32'h5A5);
        // continuous conversions keep the sequencer busy
        wr(8'h08, 8'h21);
        repeat (100) @(posedge clk);
        check({31'h0, act}, 32'h1);
        // async clock source and mode 11: light stop does not abort
        wr(8'h00, 8'h1F);
        wr(8'h08, 8'h01);
        repeat (3) @(posedge clk);
        ls <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, act}, 32'h1);
        ls <= 1'b0;
        repeat (40) @(posedge clk);
        rd_res();
        check({20'h0, r}, exp_res(2'h3, 2'h0, code));
        // both deepest stops clear everything
        for (int k = 0; k < 2; k++) begin
            wr(8'h1C, 8'h02);
            wr(8'h00, 8'h98);
            wr(8'h04, 8'h00);
            wr(8'h08, 8'h01);
            dsa <= (k == 0);
            dsb <= (k == 1);
            repeat (5) @(posedge clk);
            check({31'h0, act}, 32'h0);
            dsa <= 1'b0;
            dsb <= 1'b0;
            repeat (4) @(posedge clk);
            apb(1'b0, 8'h00, 32'h0);
            check(rd, 32'h0);
            check({11'h0, chs, pam}, 32'h0);
        end
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
